// ---- src/mcf_top.sv ----
// mac general control registers, transmit override and receive filter top
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps

// Function
// - crc fifo clear held while bit set
// - stats reset bit clears counters, self-clears
// - freeze shows snapshot, counters keep running
// - override field: normal, random loop, idles
// - 40g limit ten bits, 16-byte units, 0x280
// - 40g frames 20+ bytes over dropped
// - 100g limit eight bits, 40-byte units, 0xf0
// - 100g frames 44+ bytes over dropped
// - over-limit frames under 65536 bytes always counted too long
// - non-pause control frames removed when filtering
// - pause frames removed when filtering
// - runts removed even in promiscuous mode
// - eight bytes or less are decode errors
// - address mismatch discarded when enabled
// - fcs error frames discarded when enabled
// - promiscuous bit disables filtering except runts, decode errors and over-limit frames
// - read-only revision word per variant
// - scratch word read-write, resets zero
module mcf_top
    import mcf_pkg::*;
#(
    parameter bit P_IS_100G = 1'b0
)(
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    // apb slave
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [mcf_pkg::APB_AW-1:0] i_paddr,
    input  wire logic [mcf_pkg::APB_DW-1:0] i_pwdata,
    output logic      [mcf_pkg::APB_DW-1:0] o_prdata,
    output logic                           o_pready,
    output logic                           o_pslverr,
    // destination addresses from the address registers
    input  wire logic [47:0]               i_station_addr,
    input  wire logic [47:0]               i_group_addr,
    // receive stream from the phy side
    input  wire logic                      i_rx_valid,
    input  wire logic                      i_rx_sop,
    input  wire logic                      i_rx_eop,
    input  wire logic [2:0]                i_rx_empty,
    input  wire logic [63:0]               i_rx_data,
    input  wire logic                      i_rx_fcs_err,
    // receive stream to the client
    output logic                           o_rx_valid,
    output logic                           o_rx_sop,
    output logic                           o_rx_eop,
    output logic [2:0]                     o_rx_empty,
    output logic [63:0]                    o_rx_data,
    output logic                           o_rx_drop,
    // transmit stream from the client
    input  wire logic                      i_tx_valid,
    input  wire logic                      i_tx_sop,
    input  wire logic                      i_tx_eop,
    input  wire logic [2:0]                i_tx_empty,
    input  wire logic [63:0]               i_tx_data,
    // transmit stream to the phy side
    output logic                           o_tx_valid,
    output logic                           o_tx_sop,
    output logic                           o_tx_eop,
    output logic [2:0]                     o_tx_empty,
    output logic [63:0]                    o_tx_data,
    // diagnostic control of the transmit crc fifo
    output logic                           o_txcrc_fifo_clr
);

    localparam logic [31:0] REV_ID    = P_IS_100G ? REV_ID_100G : REV_ID_40G;
    localparam logic [9:0]  LIMIT_RST = P_IS_100G ? LIMIT_RST_100G : LIMIT_RST_40G;

    // decode of the two-bit override field
    function automatic mcf_txmode_t txo_decode(input logic [1:0] f);
        case (f)
            2'b01:   txo_decode = TXM_RANDOM;
            2'b11:   txo_decode = TXM_IDLE;
            default: txo_decode = TXM_NORMAL;
        endcase
    endfunction

    // register state
    logic [31:0]       scratch_q;
    logic              crc_clr_q;
    logic              stat_rst_q;
    logic              freeze_q;
    logic [1:0]        txo_q;
    logic [9:0]        limit_q;
    logic [5:0]        flt_q;
    logic [31:0]       cnt_q  [NUM_STATS];
    logic [31:0]       snap_q [NUM_STATS];

    // bus decode and receive events
    logic [9:0]        idx;
    logic              acc;
    logic              wr_en;
    logic [31:0]       rd_d;
    logic              err_d;
    logic [3:0]        rx_ev;

    // transmit generator
    mcf_txmode_t       mode_q;
    mcf_txmode_t       mode_want;
    logic              inframe_q;
    logic              inframe_d;
    logic [2:0]        rbeat_q;
    logic [1:0]        rframe_q;
    logic [31:0]       lfsr_q;
    logic [31:0]       lfsr_next;
    logic              nx_valid;
    logic              nx_sop;
    logic              nx_eop;
    logic [2:0]        nx_empty;
    logic [63:0]       nx_data;

    // apb access phase: first cycle prepares the answer, second completes it
    assign idx   = i_paddr[11:2];
    assign acc   = i_psel & i_penable & ~o_pready;
    assign wr_en = i_psel & i_penable & o_pready & i_pwrite;

    // read mux and unmapped detection
    always_comb
    begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (i_paddr[1:0] != 2'b00)
            err_d = 1'b1;
        else if (idx == IDX_REV)
            rd_d = REV_ID;
        else if (idx == IDX_SCRATCH)
            rd_d = scratch_q;
        else if (idx == IDX_DIAG)
            rd_d[DIAG_CRC_CLR:DIAG_TXO_LSB] = {crc_clr_q, stat_rst_q, freeze_q, txo_q};
        else if (idx == IDX_FILTER)
        begin
            rd_d[FLT_LIMIT_LSB+9:FLT_LIMIT_LSB] = P_IS_100G ? {2'b00, limit_q[7:0]} : limit_q;
            rd_d[5:0] = flt_q;
        end
        else if (idx >= IDX_STAT_BASE && idx < IDX_STAT_BASE + 10'(NUM_STATS))
            rd_d = freeze_q ? snap_q[2'(idx - IDX_STAT_BASE)] : cnt_q[2'(idx - IDX_STAT_BASE)];
        else
            err_d = 1'b1;
    end

    // apb answer flops
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready  <= acc;
            o_prdata  <= (acc && !i_pwrite) ? rd_d : 32'h0000_0000;
            o_pslverr <= acc & err_d;
        end
    end

    // scratch word, no side effects
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            scratch_q <= SCRATCH_RST;
        else if (wr_en && idx == IDX_SCRATCH && i_paddr[1:0] == 2'b00)
            scratch_q <= i_pwdata;
    end

    // diagnostic command; the revision index has no write path at all
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            {crc_clr_q, stat_rst_q, freeze_q, txo_q} <= DIAG_RST;
        else if (wr_en && idx == IDX_DIAG && i_paddr[1:0] == 2'b00)
        begin
            crc_clr_q  <= i_pwdata[DIAG_CRC_CLR];
            stat_rst_q <= i_pwdata[DIAG_STAT_RST];
            freeze_q   <= i_pwdata[DIAG_FREEZE];
            txo_q      <= i_pwdata[DIAG_TXO_LSB+1:DIAG_TXO_LSB];
        end
        else
            stat_rst_q <= 1'b0;
    end

    // filter control
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            limit_q <= LIMIT_RST;
            flt_q   <= FLT_BITS_RST;
        end
        else if (wr_en && idx == IDX_FILTER && i_paddr[1:0] == 2'b00)
        begin
            limit_q <= P_IS_100G ? {2'b00, i_pwdata[FLT_LIMIT_LSB+7:FLT_LIMIT_LSB]}
                                 : i_pwdata[FLT_LIMIT_LSB+9:FLT_LIMIT_LSB];
            flt_q   <= i_pwdata[5:0];
        end
    end

    // level held out to the crc fifo for as long as the bit is set
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_txcrc_fifo_clr <= 1'b0;
        else
            o_txcrc_fifo_clr <= crc_clr_q;
    end

    // statistics counters and freeze snapshots
    for (genvar gi = 0; gi < NUM_STATS; gi++)
    begin : g_stat
        always_ff @(posedge i_clk or posedge i_rst)
        begin
            if (i_rst)
                cnt_q[gi] <= 32'h0000_0000;
            else if (stat_rst_q)
                cnt_q[gi] <= 32'h0000_0000;
            else if (rx_ev[gi])
                cnt_q[gi] <= cnt_q[gi] + 32'h0000_0001;
        end

        // tracks live count until frozen, then holds
        always_ff @(posedge i_clk or posedge i_rst)
        begin
            if (i_rst)
                snap_q[gi] <= 32'h0000_0000;
            else if (!freeze_q)
                snap_q[gi] <= cnt_q[gi];
        end
    end

    // receive classifier
    mcf_rx_filter #(.P_IS_100G(P_IS_100G)) u_rx_filter (
        .i_clk          (i_clk),
        .i_rst          (i_rst),
        .i_limit        (limit_q),
        .i_flt          (flt_q),
        .i_station_addr (i_station_addr),
        .i_group_addr   (i_group_addr),
        .i_valid        (i_rx_valid),
        .i_sop          (i_rx_sop),
        .i_eop          (i_rx_eop),
        .i_empty        (i_rx_empty),
        .i_data         (i_rx_data),
        .i_fcs_err      (i_rx_fcs_err),
        .o_valid        (o_rx_valid),
        .o_sop          (o_rx_sop),
        .o_eop          (o_rx_eop),
        .o_empty        (o_rx_empty),
        .o_data         (o_rx_data),
        .o_drop         (o_rx_drop),
        .o_ev           (rx_ev)
    );

    // galois lfsr step for random payload
    assign lfsr_next = lfsr_q[0] ? ((lfsr_q >> 1) ^ LFSR_TAPS) : (lfsr_q >> 1);
    assign mode_want = txo_decode(txo_q);

    // next transmit beat by current mode
    always_comb
    begin
        nx_valid = 1'b0;
        nx_sop   = 1'b0;
        nx_eop   = 1'b0;
        nx_empty = 3'h0;
        nx_data  = 64'h0;
        case (mode_q)
            TXM_NORMAL:
            begin
                nx_valid = i_tx_valid;
                nx_sop   = i_tx_valid & i_tx_sop;
                nx_eop   = i_tx_valid & i_tx_eop;
                nx_empty = i_tx_empty;
                nx_data  = i_tx_data;
            end
            TXM_RANDOM:
            begin
                nx_valid = 1'b1;
                nx_sop   = (rbeat_q == 3'h0);
                nx_eop   = (rbeat_q == RND_LAST_BEAT);
                nx_data  = {lfsr_q, ~lfsr_q};
            end
            TXM_IDLE: nx_valid = 1'b0;
            default:  nx_valid = 1'b0;
        endcase
    end

    // mode changes only between frames so no frame is cut short
    assign inframe_d = (inframe_q | nx_sop) & ~nx_eop;

    // transmit mode and frame tracking
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode_q    <= TXM_NORMAL;
            inframe_q <= 1'b0;
        end
        else
        begin
            inframe_q <= inframe_d;
            if (!inframe_d)
                mode_q <= mode_want;
        end
    end

    // random loop: fixed frame count, then reseed so content repeats
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rbeat_q  <= 3'h0;
            rframe_q <= 2'h0;
            lfsr_q   <= LFSR_SEED;
        end
        else if (mode_q == TXM_RANDOM)
        begin
            rbeat_q <= rbeat_q + 3'h1;
            lfsr_q  <= lfsr_next;
            if (nx_eop)
            begin
                rframe_q <= rframe_q + 2'h1;
                if (rframe_q == RND_LAST_FRAME)
                    lfsr_q <= LFSR_SEED;
            end
        end
        else
        begin
            rbeat_q  <= 3'h0;
            rframe_q <= 2'h0;
            lfsr_q   <= LFSR_SEED;
        end
    end

    // transmit output flops
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_tx_valid <= 1'b0;
            o_tx_sop   <= 1'b0;
            o_tx_eop   <= 1'b0;
            o_tx_empty <= 3'h0;
            o_tx_data  <= 64'h0;
        end
        else
        begin
            o_tx_valid <= nx_valid;
            o_tx_sop   <= nx_sop;
            o_tx_eop   <= nx_eop;
            o_tx_empty <= nx_empty;
            o_tx_data  <= nx_data;
        end
    end

endmodule

// ---- src/mcf_pkg.sv ----
// shared constants and types for the mac control and receive filter block
package mcf_pkg;

    // apb geometry
    localparam int          APB_AW          = 12;
    localparam int          APB_DW          = 32;

    // register indices; byte address is four times the index
    localparam logic [9:0]  IDX_REV         = 10'h100;
    localparam logic [9:0]  IDX_SCRATCH     = 10'h101;
    localparam logic [9:0]  IDX_DIAG        = 10'h102;
    localparam logic [9:0]  IDX_FILTER      = 10'h103;
    localparam logic [9:0]  IDX_STAT_BASE   = 10'h104;
    localparam int          NUM_STATS       = 4;

    // statistics counter slots
    localparam int          ST_ACCEPT       = 0;
    localparam int          ST_DROP         = 1;
    localparam int          ST_TOO_LONG     = 2;
    localparam int          ST_RUNT         = 3;

    // arbitrary revision values, not tied to any real part
    localparam logic [31:0] REV_ID_40G      = 32'h0000_4a01;
    localparam logic [31:0] REV_ID_100G     = 32'h0000_4b01;
    localparam logic [31:0] SCRATCH_RST     = 32'h0000_0000;

    // diagnostic command fields
    localparam int          DIAG_CRC_CLR    = 4;
    localparam int          DIAG_STAT_RST   = 3;
    localparam int          DIAG_FREEZE     = 2;
    localparam int          DIAG_TXO_LSB    = 0;
    localparam logic [4:0]  DIAG_RST        = 5'h00;

    // filter control fields
    localparam int          FLT_LIMIT_LSB   = 8;
    localparam int          FLT_NONPAUSE    = 5;
    localparam int          FLT_PAUSE       = 4;
    localparam int          FLT_RUNT        = 3;
    localparam int          FLT_ADDR        = 2;
    localparam int          FLT_FCS         = 1;
    localparam int          FLT_PROMISC     = 0;
    localparam logic [9:0]  LIMIT_RST_40G   = 10'h280;
    localparam logic [9:0]  LIMIT_RST_100G  = 10'h0f0;
    localparam logic [5:0]  FLT_BITS_RST    = 6'h3a;
    localparam logic [15:0] LIMIT_UNIT_40G  = 16'h0010;
    localparam logic [15:0] LIMIT_UNIT_100G = 16'h0028;

    // frame classification
    localparam logic [15:0] RUNT_MIN_BYTES  = 16'h0040;
    localparam logic [15:0] DEC_ERR_BYTES   = 16'h0008;
    localparam logic [15:0] ETYPE_CONTROL   = 16'h8808;
    localparam logic [15:0] OPCODE_PAUSE    = 16'h0001;
    localparam logic [47:0] ADDR_BCAST      = 48'hffff_ffff_ffff;
    localparam logic [3:0]  BEAT_BYTES      = 4'h8;

    // diagnostic random frame loop
    localparam logic [2:0]  RND_LAST_BEAT   = 3'h7;
    localparam logic [1:0]  RND_LAST_FRAME  = 2'h3;
    localparam logic [31:0] LFSR_SEED       = 32'h1357_9bdf;
    localparam logic [31:0] LFSR_TAPS       = 32'h8020_0003;

    // transmit override modes
    typedef enum logic [2:0] {
        TXM_NORMAL = 3'b001,
        TXM_RANDOM = 3'b010,
        TXM_IDLE   = 3'b100
    } mcf_txmode_t;

endpackage

// ---- src/mcf_rx_filter.sv ----
// receive frame classifier and discard marker
`timescale 1ns/1ps

module mcf_rx_filter
    import mcf_pkg::*;
#(
    parameter bit P_IS_100G = 1'b0
)(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // configuration
    input  wire logic [9:0]  i_limit,
    input  wire logic [5:0]  i_flt,
    input  wire logic [47:0] i_station_addr,
    input  wire logic [47:0] i_group_addr,
    // incoming stream
    input  wire logic        i_valid,
    input  wire logic        i_sop,
    input  wire logic        i_eop,
    input  wire logic [2:0]  i_empty,
    input  wire logic [63:0] i_data,
    input  wire logic        i_fcs_err,
    // outgoing stream
    output logic             o_valid,
    output logic             o_sop,
    output logic             o_eop,
    output logic [2:0]       o_empty,
    output logic [63:0]      o_data,
    output logic             o_drop,
    // per-frame events
    output logic [3:0]       o_ev
);

    function automatic logic addr_hit(input logic [47:0] da, input logic [47:0] ref_addr);
        addr_hit = (da == ref_addr);
    endfunction

    logic [15:0] len_q;
    logic [15:0] len_d;
    logic        second_q;
    logic        da_ok_q;
    logic        da_ok_d;
    logic        ctl_q;
    logic        pause_q;
    logic        ctl_d;
    logic        pause_d;
    logic [15:0] limit_bytes;
    logic        too_long;
    logic        runt;
    logic        dec_err;
    logic        drop;

    // byte count including the bytes of this beat
    always_comb
    begin
        len_d = (i_sop ? 16'h0000 : len_q) + {12'h000, i_eop ? (BEAT_BYTES - {1'b0, i_empty}) : BEAT_BYTES};
        if (i_sop)
            da_ok_d = addr_hit(i_data[47:0], i_station_addr) | addr_hit(i_data[47:0], i_group_addr)
                      | addr_hit(i_data[47:0], ADDR_BCAST);
        else
            da_ok_d = da_ok_q;
        // type and opcode sit in the second beat
        ctl_d   = second_q ? ({i_data[39:32], i_data[47:40]} == ETYPE_CONTROL) : ctl_q;
        pause_d = ctl_d & (second_q ? ({i_data[55:48], i_data[63:56]} == OPCODE_PAUSE) : pause_q);
    end

    // limit in bytes for the variant
    assign limit_bytes = P_IS_100G ? 16'({8'h00, i_limit[7:0]} * LIMIT_UNIT_100G)
                                   : 16'({6'h00, i_limit} * LIMIT_UNIT_40G);

    // dropping anything over the limit covers both slack windows
    assign too_long = (len_d > limit_bytes);
    assign dec_err  = (len_d <= DEC_ERR_BYTES);
    assign runt     = ~dec_err & (len_d < RUNT_MIN_BYTES);

    // discard decision at end of frame
    always_comb
    begin
        drop = too_long | dec_err;
        if (runt && i_flt[FLT_RUNT])
            drop = 1'b1;
        if (!i_flt[FLT_PROMISC])
        begin
            drop = drop | (i_flt[FLT_FCS] & i_fcs_err)
                        | (i_flt[FLT_ADDR] & ~da_ok_d)
                        | (i_flt[FLT_PAUSE] & pause_d)
                        | (i_flt[FLT_NONPAUSE] & ctl_d & ~pause_d);
        end
    end

    // per-frame tracking state
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            len_q    <= 16'h0000;
            second_q <= 1'b0;
            da_ok_q  <= 1'b0;
            ctl_q    <= 1'b0;
            pause_q  <= 1'b0;
        end
        else if (i_valid)
        begin
            len_q    <= (!i_sop && len_d < len_q) ? 16'hffff : len_d; // sop restarts the count
            second_q <= i_sop & ~i_eop;
            da_ok_q  <= da_ok_d;
            ctl_q    <= i_sop ? 1'b0 : ctl_d;
            pause_q  <= i_sop ? 1'b0 : pause_d;
        end
    end

    // registered stream with discard mark on the last beat
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_valid <= 1'b0;
            o_sop   <= 1'b0;
            o_eop   <= 1'b0;
            o_empty <= 3'h0;
            o_data  <= 64'h0;
            o_drop  <= 1'b0;
            o_ev    <= 4'h0;
        end
        else
        begin
            o_valid            <= i_valid;
            o_sop              <= i_valid & i_sop;
            o_eop              <= i_valid & i_eop;
            o_empty            <= i_empty;
            o_data             <= i_data;
            o_drop             <= i_valid & i_eop & drop;
            o_ev[ST_ACCEPT]    <= i_valid & i_eop & ~drop;
            o_ev[ST_DROP]      <= i_valid & i_eop & drop;
            o_ev[ST_TOO_LONG]  <= i_valid & i_eop & too_long;
            o_ev[ST_RUNT]      <= i_valid & i_eop & runt;
        end
    end

endmodule

// ---- dv/mcf_properties.sv ----
// concurrent checks on the ports of the mac control and filter top
`timescale 1ns/1ps
module mcf_properties
    import mcf_pkg::*;
#(
    parameter bit P_IS_100G = 1'b0
)(
    // clock, reset and apb
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // receive stream and diagnostics
    input wire logic        i_rx_valid,
    input wire logic        i_rx_sop,
    input wire logic        i_rx_eop,
    input wire logic [63:0] i_rx_data,
    input wire logic        o_rx_valid,
    input wire logic [63:0] o_rx_data,
    input wire logic        o_rx_eop,
    input wire logic        o_rx_drop,
    input wire logic        o_txcrc_fifo_clr
);
    localparam logic [31:0] REV = P_IS_100G ? REV_ID_100G : REV_ID_40G;
    wire acc = i_psel && i_penable && o_pready;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_PREADY_WAIT: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("late pready");
    AST_PREADY_ONE: assert property (o_pready |=> !o_pready) else $error("pready too long");
    AST_ERR_RDY: assert property (o_pslverr |-> o_pready) else $error("stray pslverr");
    AST_RDATA_IDLE: assert property (!o_pready |-> o_prdata == 32'h0) else $error("prdata not idle");
    AST_UNMAPPED: assert property (acc && (i_paddr >= 12'h420 || i_paddr < 12'h400) |-> o_pslverr)
        else $error("no pslverr");
    AST_REV: assert property (acc && !i_pwrite && i_paddr == 12'h400 |-> o_prdata == REV)
        else $error("bad revision");
    AST_CRC: assert property (acc && i_pwrite && i_paddr == 12'h408 |-> ##2 o_txcrc_fifo_clr == $past(i_pwdata[4], 2))
        else $error("crc clear wrong");
    AST_RX_PASS: assert property (i_rx_valid |=> o_rx_valid && o_rx_data == $past(i_rx_data))
        else $error("rx beat lost");
    AST_DROP_EOP: assert property (o_rx_drop |-> o_rx_eop && o_rx_valid) else $error("drop off eop");
    AST_DECERR: assert property (i_rx_valid && i_rx_sop && i_rx_eop |=> o_rx_drop)
        else $error("short frame kept");
    // main scenarios reached
    COV_DROP: cover property (o_rx_drop);
    COV_ERR: cover property (o_pslverr);
    COV_CRC: cover property ($rose(o_txcrc_fifo_clr));
endmodule

// ---- dv/mcf_link_model.sv ----
// link partner model sending receive frames into the filter
`timescale 1ns/1ps
module mcf_link_model (
    input  wire logic i_clk,
    output logic        o_valid, o_sop, o_eop, o_fcs_err,
    output logic [2:0]  o_empty,
    output logic [63:0] o_data
);
    initial {o_valid, o_sop, o_eop, o_fcs_err, o_empty, o_data} = '0;
    // one frame, 8 bytes a beat, byte 0 in the low lane
    task send(input int n, input logic [47:0] da, input logic [15:0] et, op, input logic fe);
        logic [63:0] d;
        logic [7:0]  by;
        d = '0;
        for (int b = 0; b < n; b++)
        begin
            by = b < 6 ? da[8*b+:8] : b == 12 ? et[15:8] : b == 13 ? et[7:0] :
                 b == 14 ? op[15:8] : b == 15 ? op[7:0] : 8'(b);
            d[8*(b%8)+:8] = by;
            if (b % 8 == 7 || b == n - 1)
            begin
                @(posedge i_clk);
                {o_valid, o_sop, o_eop, o_fcs_err} <= {1'b1, b < 8, b == n - 1, fe};
                o_empty <= 3'(7 - b % 8);
                o_data  <= d;
            end
        end
        // released line shows the inverse, not a held value
        @(posedge i_clk);
        {o_valid, o_sop, o_eop} <= 3'h0;
        o_data <= ~d;
    endtask
endmodule

// ---- dv/test_mac_control_rx_filter.sv ----
// self-checking bench for the mac control and receive filter top
`timescale 1ns/1ps
module test_mac_control_rx_filter;
    import mcf_pkg::*;
    localparam logic [47:0] ST = 48'h0200_0000_0001;
    logic i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, o_pready, o_pslverr;
    logic [11:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata, rd;
    logic [47:0] i_station_addr = ST, i_group_addr = 48'h0300_0000_0005;
    logic i_rx_valid, i_rx_sop, i_rx_eop, i_rx_fcs_err, o_rx_valid, o_rx_sop, o_rx_eop, o_rx_drop;
    logic [2:0] i_rx_empty, o_rx_empty, i_tx_empty = 0, o_tx_empty;
    logic [63:0] i_rx_data, o_rx_data, i_tx_data = 0, o_tx_data;
    logic i_tx_valid = 1, tph = 0, o_tx_valid, o_tx_sop, o_tx_eop, o_txcrc_fifo_clr, seen_drop = 0;
    wire i_tx_sop = ~tph;
    wire i_tx_eop = tph;
    int failures = 0, n_checks = 0;
    mcf_top DUT (.*);
    mcf_link_model lm (.i_clk(i_clk), .o_valid(i_rx_valid), .o_sop(i_rx_sop), .o_eop(i_rx_eop),
        .o_fcs_err(i_rx_fcs_err), .o_empty(i_rx_empty), .o_data(i_rx_data));
    initial forever #5 i_clk = ~i_clk;
    // two-beat client frames back to back
    always @(posedge i_clk)
    begin
        tph <= ~tph;
        i_tx_data <= i_tx_data + 64'h1;
    end
    always @(posedge i_clk) if (o_rx_eop === 1'b1) seen_drop <= o_rx_drop;
    task report_and_stop;
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // apb transfer, held until pready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_pslverr ? 32'hdead_0000 | o_prdata : o_prdata;
        {i_psel, i_penable} <= 2'b00;
    endtask
    task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(nm, rd, e);
    endtask
    task fr(input int n, input logic [47:0] da, input logic [15:0] et, op, input logic fe, ex);
        lm.send(n, da, et, op, fe);
        repeat (3) @(posedge i_clk);
        chk("drop", seen_drop, ex);
    endtask
    task t_regs;
        rchk("scratch", 12'h404, 0);
        rchk("diag", 12'h408, 0);
        rchk("filter", 12'h40c, 32'h0002_803a);
        apb(1, 12'h400, 32'hffff_ffff);
        rchk("rev", 12'h400, REV_ID_40G);
        rchk("filter", 12'h40c, 32'h0002_803a);
        apb(1, 12'h404, 32'ha5c3_0f96);
        rchk("scratch", 12'h404, 32'ha5c3_0f96);
        rchk("unmapped", 12'h420, 32'hdead_0000);
    endtask
    task t_crc;
        apb(1, 12'h408, 32'h10);
        repeat (20) @(posedge i_clk);
        chk("crcclr", o_txcrc_fifo_clr, 1);
        apb(1, 12'h408, 0);
        repeat (2) @(negedge i_clk);
        chk("crcclr", o_txcrc_fifo_clr, 0);
    endtask
    task t_filter;
        apb(1, 12'h40c, 32'h43a);
        fr(64, ST, 16'h0800, 0, 0, 0);
        fr(8, ST, 16'h0800, 0, 0, 1);
        fr(40, ST, 16'h0800, 0, 0, 1);
        fr(64, ST, 16'h0800, 0, 1, 1);
        fr(64, ST, 16'h8808, 1, 0, 1);
        fr(64, ST, 16'h8808, 2, 0, 1);
        fr(84, ST, 16'h0800, 0, 0, 1);
        rchk("toolong", 12'h418, 1);
        rchk("runt", 12'h41c, 1);
        apb(1, 12'h40c, 32'h43e);
        fr(64, ST + 48'h9, 16'h0800, 0, 0, 1);
        fr(64, i_group_addr, 16'h0800, 0, 0, 0);
        apb(1, 12'h40c, 32'h43b);
        fr(64, ST, 16'h8808, 1, 1, 0);
        fr(40, ST, 16'h0800, 0, 0, 1);
    endtask
    task t_stats;
        apb(1, 12'h408, 32'h8);
        rchk("diag", 12'h408, 0);
        rchk("toolong", 12'h418, 0);
        apb(1, 12'h408, 32'h4);
        fr(64, ST, 16'h0800, 0, 0, 0);
        rchk("frozen", 12'h410, 0);
        apb(1, 12'h408, 0);
        rchk("live", 12'h410, 1);
    endtask
    task t_tx;
        logic [31:0] v, s;
        logic [1:0] m [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
        int es [4] = '{8, 2, 0, 8};
        for (int k = 0; k < 4; k++)
        begin
            apb(1, 12'h408, {30'h0, m[k]});
            repeat (12) @(posedge i_clk);
            {v, s} = 0;
            repeat (16) @(negedge i_clk) {v, s} = {v + o_tx_valid, s + o_tx_sop};
            chk("txvalid", v, es[k] ? 16 : 0);
            chk("txsop", s, es[k]);
        end
    endtask
    initial
    begin
        #500us;
        failures++;
        report_and_stop;
    end
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs;
        t_crc;
        t_filter;
        t_stats;
        t_tx;
        report_and_stop;
    end
endmodule
bind mcf_top mcf_properties #(.P_IS_100G(P_IS_100G)) u_prop (.*);
